// file: dlr_pkg.sv
package dlr_pkg;

  // ****************************************************************
  // Register offsets on the device register port
  // ****************************************************************
  localparam logic [7:0] DLR_OFS_EQ_TEST = 8'h35;      // Equalizer test control
  localparam logic [7:0] DLR_OFS_STRAP = 8'h37;        // Strap decode status
  localparam logic [7:0] DLR_OFS_DIVSEL = 8'h3a;       // Audio clock divider select
  localparam logic [7:0] DLR_OFS_EQUALIZER_STATUS = 8'h3b; // Equalizer status
  localparam logic [7:0] DLR_OFS_LINK_ERR = 8'h41;     // Link error threshold
  localparam logic [7:0] DLR_OFS_DUAL_RX = 8'h34;      // Port select register
  localparam logic [7:0] DLR_OFS_EQ_BYPASS = 8'h44;    // Manual equalizer bypass

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DLR_EQT_FLOOR_OV_BIT = 5;             // Floor override enable
  localparam int DLR_EQT_FLOOR_BIT = 4;                // Floor start
  localparam int DLR_ST1_DONE_BIT = 7;                 // Strap-1 latched flag
  localparam int DLR_ST0_DONE_BIT = 3;                 // Strap-0 latched flag
  localparam int DLR_DIV_POST_OV_BIT = 7;              // Post divider override
  localparam int DLR_DIV_PRE_OV_BIT = 2;               // Pre divider override
  localparam int DLR_LEC_EN_BIT = 4;                   // Error count enable
  localparam int DLR_PORT_SEL_BIT = 1;                 // Second port select
  localparam int DLR_BYP_EN_BIT = 0;                   // Equalizer bypass

  // ****************************************************************
  // Writable masks and reset values
  // ****************************************************************
  localparam logic [7:0] DLR_EQT_MASK = 8'h30;
  localparam logic [7:0] DLR_DIVSEL_MASK = 8'hf7;
  localparam logic [7:0] DLR_LINK_ERR_MASK = 8'h1f;
  localparam logic [7:0] DLR_DUAL_RX_MASK = 8'h02;
  localparam logic [7:0] DLR_EQ_BYPASS_MASK = 8'hef;
  localparam logic [7:0] DLR_RST_ZERO = 8'h00;
  localparam logic [7:0] DLR_RST_LINK_ERR = 8'h03;
  localparam logic [7:0] DLR_RST_EQ_BYPASS = 8'h60;
  localparam logic [3:0] DLR_THRESH_ONE = 4'h1;        // Threshold when counting is off

  // ****************************************************************
  // Types
  // ****************************************************************
  // One receive port's error event inputs
  typedef struct packed {
    logic clk0_err;
    logic clk1_err;
    logic ctl_err;
  } dlr_link_err_t;

  // Error counter states
  typedef enum logic [1:0] {
    DLR_LS_LOCKED = 2'b00,
    DLR_LS_COUNT = 2'b01,
    DLR_LS_DROP = 2'b11
  } dlr_lock_state_t;

endpackage

// file: dlr_err_counter.sv
`timescale 1ns/1ps
`default_nettype none

module dlr_err_counter
  import dlr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic count_en_i,
  input wire logic [3:0] threshold_i,
  input wire logic relock_i,
  input wire dlr_link_err_t err_i,
  // Status
  output logic lock_drop_o,
  output logic [3:0] err_count_o
);

  // ****************************************************************
  // Error counter, one per receive port
  // ****************************************************************
  dlr_lock_state_t state_r;
  logic [3:0] count_r;
  logic any_err;
  logic [3:0] limit;
  logic [3:0] count_nxt;

  // Any of the three monitored streams
  assign any_err = |err_i;
  // Disabled counting means a single error drops lock
  assign limit = count_en_i ? threshold_i : DLR_THRESH_ONE;
  assign count_nxt = (count_r == 4'hf) ? count_r : count_r + 4'h1;

  // Count errors and drop lock at the limit
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= DLR_LS_LOCKED;
      count_r <= 4'h0;
    end else begin
      case (state_r)
        DLR_LS_LOCKED,
        DLR_LS_COUNT: begin
          if (any_err) begin
            count_r <= count_nxt;
            // Zero threshold treated as one, so lock is never dropped idle
            if (count_nxt >= limit) begin
              state_r <= DLR_LS_DROP;
            end else begin
              state_r <= DLR_LS_COUNT;
            end
          end
        end
        DLR_LS_DROP: begin
          // Held until the link relocks
          if (relock_i) begin
            state_r <= DLR_LS_LOCKED;
            count_r <= 4'h0;
          end
        end
        default: begin
          state_r <= DLR_LS_LOCKED;
          count_r <= 4'h0;
        end
      endcase
    end
  end

  assign lock_drop_o = (state_r == DLR_LS_DROP);
  assign err_count_o = count_r;

  // One error with counting off drops lock next cycle
  a_single_err_drop: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state_r != DLR_LS_DROP) && !count_en_i && any_err |=> lock_drop_o)
    else $error("lock not dropped on first error");

  // Below threshold no drop
  a_thresh_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state_r == DLR_LS_LOCKED) && count_en_i && (threshold_i > 4'h2) && any_err
      |=> !lock_drop_o && (count_r == 4'h1))
    else $error("lock dropped below threshold");

endmodule // dlr_err_counter

`default_nettype wire

// file: dlr_link_eq_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Floor start begins adaptation from preset floor
// - Strap-1 latched flag reads 1 after latch
// - Strap-1 code in bits 6-4, read-only
// - Strap-0 latched flag reads 1 after latch
// - Strap-0 code in bits 2-0, read-only
// - Post divider override selects software divider
// - Post divider code gives 32..1 division
// - Pre divider override replaces state machine ratio
// - Pre divider code divides by 1,2,4,8
// - Bypass returns manual stage two, one settings
// - Adaptive mode reports adaptive equalizer setting
// - Second port select reads second port status
// - Error count enable turns counting on
// - Drop lock when count reaches threshold
// - Counting disabled drops lock on first error
// - Port select steers per-port register accesses
// - Floor start needs floor override enable

module dlr_link_eq_regs
  import dlr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Strap pins and decoder
  input wire logic [2:0] strap0_level_i,
  input wire logic [2:0] strap1_level_i,
  input wire logic strap_sample_i,
  // Adaptive equalizer
  input wire logic [5:0] auto_eq_setting0_i,
  input wire logic [5:0] auto_eq_setting1_i,
  output logic [5:0] eq_analog0_o,
  output logic [5:0] eq_analog1_o,
  output logic [1:0] eq_floor_start_o,
  // Audio clock dividers
  input wire logic [1:0] pll_state_machine_div_i,
  output logic [5:0] post_div_ratio_o,
  output logic [3:0] pre_div_ratio_o,
  // Link integrity
  input wire dlr_link_err_t link_err0_i,
  input wire dlr_link_err_t link_err1_i,
  input wire logic [1:0] relock_i,
  output logic [1:0] lock_drop_o
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Post divider code to ratio
  function automatic logic [5:0] post_div(input logic [2:0] code);
    case (code)
      3'b000: post_div = 6'd32;
      3'b001: post_div = 6'd16;
      3'b010: post_div = 6'd8;
      3'b011: post_div = 6'd4;
      3'b100,
      3'b101: post_div = 6'd2;
      default: post_div = 6'd1;
    endcase
  endfunction

  // Pre divider code to ratio
  function automatic logic [3:0] pre_div(input logic [1:0] code);
    pre_div = 4'h1 << code;
  endfunction

  // Equalizer value seen by the analog stage
  function automatic logic [5:0] eq_pick(input logic [7:0] byp, input logic [5:0] auto_v);
    if (byp[DLR_BYP_EN_BIT]) begin
      eq_pick = {byp[3:1], byp[7:5]};
    end else begin
      eq_pick = auto_v;
    end
  endfunction

  // ****************************************************************
  // Strap synchronisers
  // ****************************************************************
  logic [5:0] strap_meta_r;
  logic [5:0] strap_sync_r;
  logic [1:0] samp_meta_r;
  logic [1:0] samp_sync_r;

  // Pins arrive asynchronously; two flops for the levels and four for the sample before use
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_meta_r <= 6'h00;
      strap_sync_r <= 6'h00;
      samp_meta_r <= 2'b00;
      samp_sync_r <= 2'b00;
    end else begin
      strap_meta_r <= {strap1_level_i, strap0_level_i};
      strap_sync_r <= strap_meta_r;
      samp_meta_r <= {samp_meta_r[0], strap_sample_i};
      samp_sync_r <= {samp_sync_r[0], samp_meta_r[1]};
    end
  end

  // ****************************************************************
  // Strap latch
  // ****************************************************************
  logic [2:0] strap0_code_r;
  logic [2:0] strap1_code_r;
  logic strap0_decode_latched_r;
  logic strap1_decode_latched_r;
  logic samp_ok;

  assign samp_ok = samp_sync_r[1];

  // Latched once after reset; codes are frozen thereafter
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap0_code_r <= 3'b000;
      strap1_code_r <= 3'b000;
      strap0_decode_latched_r <= 1'b0;
      strap1_decode_latched_r <= 1'b0;
    end else if (samp_ok && !strap0_decode_latched_r) begin
      strap0_code_r <= strap_sync_r[2:0];
      strap1_code_r <= strap_sync_r[5:3];
      strap0_decode_latched_r <= 1'b1;
      strap1_decode_latched_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  logic [7:0] port_sel_r;
  logic [7:0] eq_test0_r;
  logic [7:0] eq_test1_r;
  logic [7:0] eq_byp0_r;
  logic [7:0] eq_byp1_r;
  logic [7:0] divsel_r;
  logic [7:0] link_err_r;
  logic sel1;

  assign sel1 = port_sel_r[DLR_PORT_SEL_BIT];

  // Shared registers; masks keep reserved bits at zero
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_sel_r <= DLR_RST_ZERO;
      divsel_r <= DLR_RST_ZERO;
      link_err_r <= DLR_RST_LINK_ERR;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        DLR_OFS_DUAL_RX: port_sel_r <= reg_wdata_i & DLR_DUAL_RX_MASK;
        DLR_OFS_DIVSEL: divsel_r <= reg_wdata_i & DLR_DIVSEL_MASK;
        DLR_OFS_LINK_ERR: link_err_r <= reg_wdata_i & DLR_LINK_ERR_MASK;
        default: begin
        end
      endcase
    end
  end

  // Per-port registers follow the port select
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      eq_test0_r <= DLR_RST_ZERO;
      eq_test1_r <= DLR_RST_ZERO;
      eq_byp0_r <= DLR_RST_EQ_BYPASS;
      eq_byp1_r <= DLR_RST_EQ_BYPASS;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        DLR_OFS_EQ_TEST: begin
          if (sel1) begin
            eq_test1_r <= reg_wdata_i & DLR_EQT_MASK;
          end else begin
            eq_test0_r <= reg_wdata_i & DLR_EQT_MASK;
          end
        end
        DLR_OFS_EQ_BYPASS: begin
          if (sel1) begin
            eq_byp1_r <= reg_wdata_i & DLR_EQ_BYPASS_MASK;
          end else begin
            eq_byp0_r <= reg_wdata_i & DLR_EQ_BYPASS_MASK;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Equalizer and divider outputs
  // ****************************************************************
  logic [5:0] eq_set0;
  logic [5:0] eq_set1;

  assign eq_set0 = eq_pick(eq_byp0_r, auto_eq_setting0_i);
  assign eq_set1 = eq_pick(eq_byp1_r, auto_eq_setting1_i);

  // Data outputs registered
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      eq_analog0_o <= 6'h00;
      eq_analog1_o <= 6'h00;
      eq_floor_start_o <= 2'b00;
      post_div_ratio_o <= 6'd0;
      pre_div_ratio_o <= 4'h0;
    end else begin
      eq_analog0_o <= eq_set0;
      eq_analog1_o <= eq_set1;
      // Floor start gated by its override enable
      eq_floor_start_o <= {eq_test1_r[DLR_EQT_FLOOR_BIT] & eq_test1_r[DLR_EQT_FLOOR_OV_BIT],
        eq_test0_r[DLR_EQT_FLOOR_BIT] & eq_test0_r[DLR_EQT_FLOOR_OV_BIT]};
      // Zero ratio means no override; block uses its own default
      post_div_ratio_o <= divsel_r[DLR_DIV_POST_OV_BIT] ? post_div(divsel_r[6:4]) : 6'd0;
      pre_div_ratio_o <= divsel_r[DLR_DIV_PRE_OV_BIT] ? pre_div(divsel_r[1:0])
        : pre_div(pll_state_machine_div_i);
    end
  end

  // ****************************************************************
  // Error counters
  // ****************************************************************
  logic [3:0] thresh;

  assign thresh = link_err_r[3:0];

  dlr_err_counter u_err0 (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .count_en_i(link_err_r[DLR_LEC_EN_BIT]),
    .threshold_i(thresh),
    .relock_i(relock_i[0]),
    .err_i(link_err0_i),
    .lock_drop_o(lock_drop_o[0]),
    .err_count_o()
  );

  dlr_err_counter u_err1 (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .count_en_i(link_err_r[DLR_LEC_EN_BIT]),
    .threshold_i(thresh),
    .relock_i(relock_i[1]),
    .err_i(link_err1_i),
    .lock_drop_o(lock_drop_o[1]),
    .err_count_o()
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] rd_mux;

  // Combinational decode, registered output; unmapped reads zero
  always_comb begin
    case (reg_addr_i)
      DLR_OFS_DUAL_RX: rd_mux = port_sel_r;
      DLR_OFS_EQ_TEST: rd_mux = sel1 ? eq_test1_r : eq_test0_r;
      DLR_OFS_STRAP: rd_mux = {strap1_decode_latched_r, strap1_code_r,
        strap0_decode_latched_r, strap0_code_r};
      DLR_OFS_DIVSEL: rd_mux = divsel_r;
      DLR_OFS_EQUALIZER_STATUS: rd_mux = {2'b00, sel1 ? eq_set1 : eq_set0};
      DLR_OFS_LINK_ERR: rd_mux = link_err_r;
      DLR_OFS_EQ_BYPASS: rd_mux = sel1 ? eq_byp1_r : eq_byp0_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data sampled on the read strobe
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_floor_gate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !eq_test0_r[DLR_EQT_FLOOR_OV_BIT] |=> !eq_floor_start_o[0])
    else $error("floor start without override");

  a_bypass_read: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    reg_rd_i && reg_addr_i == DLR_OFS_EQUALIZER_STATUS && !sel1 && eq_byp0_r[0]
      |=> reg_rdata_o == {2'b00, $past(eq_byp0_r[3:1]), $past(eq_byp0_r[7:5])})
    else $error("bypass status mismatch");

  a_strap_done: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    strap0_decode_latched_r |=> strap0_decode_latched_r && $stable(strap0_code_r))
    else $error("strap latch changed");

  // Sample held through the synchroniser chain latches both straps
  sequence s_sample_steady;
    strap_sample_i [*5];
  endsequence

  a_strap_latch: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    s_sample_steady |=> strap1_decode_latched_r && strap0_decode_latched_r)
    else $error("strap decode not latched");

  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ((link_err_r & ~DLR_LINK_ERR_MASK) == 8'h00) && ((divsel_r & ~DLR_DIVSEL_MASK) == 8'h00))
    else $error("reserved bit set");

  a_post_div: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    divsel_r[7] && divsel_r[6:4] == 3'b000 |=> post_div_ratio_o == 6'd32)
    else $error("post divider wrong");

  a_pre_div: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !divsel_r[2] && pll_state_machine_div_i == 2'b11 |=> pre_div_ratio_o == 4'h8)
    else $error("pre divider not from state machine");

endmodule // dlr_link_eq_regs

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import dlr_pkg::*;
;
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  logic clk = 1'b0;                 // Core clock, 25 MHz
  logic rst_b = 1'b0;               // Async reset, active low
  logic wr_s = 1'b0;                // Register write strobe
  logic rd_s = 1'b0;                // Register read strobe
  logic [7:0] addr = 8'h00;         // Register offset
  logic [7:0] wdata = 8'h00;        // Write data
  logic [7:0] rdata;                // Read data from the bank
  logic [2:0] strap0 = 3'b000;      // Strap-0 levels
  logic [2:0] strap1 = 3'b000;      // Strap-1 levels
  logic sample = 1'b0;              // Strap decode valid
  logic [5:0] auto0 = 6'h00;        // Adaptive choice, port 0
  logic [5:0] auto1 = 6'h00;        // Adaptive choice, port 1
  logic [5:0] an0;                  // Analog setting, port 0
  logic [5:0] an1;                  // Analog setting, port 1
  logic [1:0] floor_o;              // Floor start per port
  logic [1:0] pll_pre = 2'b00;      // State machine pre divider code
  logic [5:0] post_o;               // Post divider ratio
  logic [3:0] pre_o;                // Pre divider ratio
  dlr_link_err_t err0 = 3'b000;     // Error events, port 0
  dlr_link_err_t err1 = 3'b000;     // Error events, port 1
  logic [1:0] relock = 2'b00;       // Relock request per port
  logic [1:0] drop;                 // Lock dropped per port
  int err_total = 0;                // Mismatch count
  int checks = 0;                   // Comparison count

  // Half period of 20 ns
  always #20 clk = ~clk;

  dlr_link_eq_regs dut (
    .core_clk_i(clk), .rst_b_i(rst_b),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .strap0_level_i(strap0), .strap1_level_i(strap1), .strap_sample_i(sample),
    .auto_eq_setting0_i(auto0), .auto_eq_setting1_i(auto1),
    .eq_analog0_o(an0), .eq_analog1_o(an1), .eq_floor_start_o(floor_o),
    .pll_state_machine_div_i(pll_pre), .post_div_ratio_o(post_o), .pre_div_ratio_o(pre_o),
    .link_err0_i(err0), .link_err1_i(err1), .relock_i(relock), .lock_drop_o(drop)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Verdict in one place; a used-up wait also lands here
  task automatic conclude();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compare seen against expected, four-state exact
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Let n edges pass, then step just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One write; idle edge after so the strobe never toggles twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    tick(1);
    wr_s = 1'b0;
    tick(1);
  endtask

  // One read and compare; data is registered at the read edge
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    addr = a;
    rd_s = 1'b1;
    tick(1);
    rd_s = 1'b0;
    chk(rdata, exp, what);
    tick(1);
  endtask

  // Error burst of n events, rotating over the three streams
  task automatic burst(input int p, input int n);
    for (int i = 0; i < n; i++) begin
      if (p == 0) err0 = dlr_link_err_t'(3'b001 << (i % 3));
      else err1 = dlr_link_err_t'(3'b001 << (i % 3));
      tick(1);
    end
    err0 = 3'b000;
    err1 = 3'b000;
    tick(1);
  endtask

  // Bounded wait for the lock flags; a miss ends the run
  task automatic wait_drop(input logic [1:0] exp);
    for (int i = 0; i < 4; i++) begin
      if (drop === exp) break;
      tick(1);
    end
    chk({6'h00, drop}, {6'h00, exp}, "lock drop");
    if (drop !== exp) conclude();
  endtask

  // Relock both ports and confirm the flags clear
  task automatic do_relock();
    relock = 2'b11;
    tick(1);
    relock = 2'b00;
    tick(1);
    wait_drop(2'b00);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values and an unmapped offset
  task automatic t_reset();
    rchk(DLR_OFS_STRAP, 8'h00, "strap before latch");
    rchk(DLR_OFS_DIVSEL, 8'h00, "divsel reset");
    rchk(DLR_OFS_LINK_ERR, 8'h03, "threshold reset");
    rchk(DLR_OFS_EQUALIZER_STATUS, 8'h00, "eq setting reset");
    rchk(8'h77, 8'h00, "unmapped read");
    chk({2'b00, post_o}, 8'h00, "post div idle");
    $display("t_reset done");
  endtask

  // Strap latch: zero before, code after, frozen after
  task automatic t_strap();
    strap0 = 3'b101;
    strap1 = 3'b110;
    sample = 1'b1;
    tick(1);
    rchk(DLR_OFS_STRAP, 8'h00, "strap too early");
    tick(3);
    rchk(DLR_OFS_STRAP, 8'hed, "strap latched");
    strap0 = 3'b010;
    strap1 = 3'b001;
    wr(DLR_OFS_STRAP, 8'h00);
    tick(4);
    rchk(DLR_OFS_STRAP, 8'hed, "strap frozen");
    $display("t_strap done");
  endtask

  // Every divider code, with and without override
  task automatic t_div();
    logic [5:0] pd;
    for (int c = 0; c < 8; c++) begin
      pd = (c < 4) ? (6'd32 >> c) : ((c < 6) ? 6'd2 : 6'd1);
      wr(DLR_OFS_DIVSEL, {1'b1, 3'(c), 2'b11, 2'(c)});
      tick(1);
      chk({2'b00, post_o}, {2'b00, pd}, "post div");
      chk({4'h0, pre_o}, {4'h0, 4'd1 << (c % 4)}, "pre div sw");
      rchk(DLR_OFS_DIVSEL, {1'b1, 3'(c), 2'b01, 2'(c)}, "divsel readback");
    end
    wr(DLR_OFS_DIVSEL, 8'h00);
    for (int p = 0; p < 4; p++) begin
      pll_pre = 2'(p);
      tick(2);
      chk({4'h0, pre_o}, {4'h0, 4'd1 << p}, "pre div state machine");
      chk({2'b00, post_o}, 8'h00, "post div released");
    end
    $display("t_div done");
  endtask

  // Adaptive, bypass, second port and floor start
  task automatic t_eq();
    auto0 = 6'h2a;
    auto1 = 6'h15;
    tick(2);
    rchk(DLR_OFS_EQUALIZER_STATUS, 8'h2a, "adaptive status");
    chk({2'b00, an0}, 8'h2a, "adaptive analog");
    wr(DLR_OFS_EQ_BYPASS, 8'hb7);
    tick(1);
    rchk(DLR_OFS_EQ_BYPASS, 8'ha7, "bypass readback");
    rchk(DLR_OFS_EQUALIZER_STATUS, 8'h1d, "bypass status");
    chk({2'b00, an0}, 8'h1d, "bypass analog");
    chk({2'b00, an1}, 8'h15, "port1 untouched");
    wr(DLR_OFS_DUAL_RX, 8'h02);
    rchk(DLR_OFS_EQUALIZER_STATUS, 8'h15, "second port status");
    rchk(DLR_OFS_EQ_BYPASS, 8'h60, "second port bypass");
    // Floor start alone must do nothing
    wr(DLR_OFS_EQ_TEST, 8'h10);
    tick(1);
    chk({6'h00, floor_o}, 8'h00, "floor without enable");
    wr(DLR_OFS_EQ_TEST, 8'hff);
    tick(1);
    chk({6'h00, floor_o}, 8'h02, "floor on port1");
    rchk(DLR_OFS_EQ_TEST, 8'h30, "test readback");
    wr(DLR_OFS_DUAL_RX, 8'h00);
    rchk(DLR_OFS_EQUALIZER_STATUS, 8'h1d, "first port again");
    rchk(DLR_OFS_EQ_TEST, 8'h00, "first port test reg");
    // Port 0 gating too, so a broken enable on either port shows
    wr(DLR_OFS_EQ_TEST, 8'h10);
    tick(1);
    chk({6'h00, floor_o}, 8'h02, "port0 floor without enable");
    wr(DLR_OFS_EQ_TEST, 8'h30);
    tick(1);
    chk({6'h00, floor_o}, 8'h03, "floor on both ports");
    $display("t_eq done");
  endtask

  // Threshold counting, relock, and first-error drop
  task automatic t_err();
    wr(DLR_OFS_LINK_ERR, 8'hf3);
    rchk(DLR_OFS_LINK_ERR, 8'h13, "threshold readback");
    burst(0, 2);
    tick(1);
    chk({6'h00, drop}, 8'h00, "below threshold");
    burst(0, 1);
    wait_drop(2'b01);
    do_relock();
    // Counting off: one error is enough
    wr(DLR_OFS_LINK_ERR, 8'h03);
    burst(0, 1);
    wait_drop(2'b01);
    do_relock();
    // Counting on again with threshold two, second port
    wr(DLR_OFS_LINK_ERR, 8'h12);
    burst(1, 1);
    tick(1);
    chk({6'h00, drop}, 8'h00, "one of two");
    burst(1, 1);
    wait_drop(2'b10);
    do_relock();
    // Zero threshold behaves as one
    wr(DLR_OFS_LINK_ERR, 8'h10);
    burst(0, 1);
    wait_drop(2'b01);
    do_relock();
    $display("t_err done");
  endtask

  // Mid-run reset: registers return to reset values, straps relatch
  task automatic t_rerst();
    wr(DLR_OFS_DIVSEL, 8'h84);
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(1);
    // Sample chain restarts, so the first read is still too early
    rchk(DLR_OFS_STRAP, 8'h00, "strap cleared by reset");
    rchk(DLR_OFS_DIVSEL, 8'h00, "divsel after reset");
    rchk(DLR_OFS_LINK_ERR, 8'h03, "threshold after reset");
    rchk(DLR_OFS_EQ_BYPASS, 8'h60, "bypass after reset");
    rchk(DLR_OFS_STRAP, 8'h9a, "strap relatched");
    chk({2'b00, post_o}, 8'h00, "post div after reset");
    $display("t_rerst done");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    tick(1);
    t_reset();
    t_strap();
    t_div();
    t_eq();
    t_err();
    t_rerst();
    conclude();
  end
endmodule // tb_top

`default_nettype wire
